// ==== hw/umib_pkg.sv ====
// constants shared by the modem-input, bus-pin and receive logic
// assumes a single 10 MHz clock; all pins arrive synchronous to it or are synchronised here
package umib_pkg;

    // register select codes on the three address pins
    localparam logic [2:0] UMIB_ADDR_DATA = 3'h0;
    localparam logic [2:0] UMIB_ADDR_IRQ_MASK = 3'h1;
    localparam logic [2:0] UMIB_ADDR_MODEM_CTL = 3'h4;
    localparam logic [2:0] UMIB_ADDR_LINE_STATE = 3'h5;
    localparam logic [2:0] UMIB_ADDR_MODEM_STATE = 3'h6;

    // irq_mask_reg fields
    localparam int UMIB_IRQ_RX_AVAIL = 0;
    localparam int UMIB_IRQ_TX_EMPTY = 1;
    localparam int UMIB_IRQ_LINE_ERR = 2;
    localparam int UMIB_IRQ_MODEM = 3;
    localparam int UMIB_IRQ_MASK_W = 4;
    localparam logic [3:0] UMIB_IRQ_MASK_RST = 4'h0;

    // modem_ctl_reg fields
    localparam int UMIB_MCTL_TERM_READY = 0;
    localparam int UMIB_MCTL_SEND_REQ = 1;
    localparam int UMIB_MCTL_AUX1 = 2;
    localparam int UMIB_MCTL_AUX2 = 3;
    localparam int UMIB_MCTL_LOOP = 4;
    localparam int UMIB_MCTL_W = 5;
    localparam logic [4:0] UMIB_MCTL_RST = 5'h00;

    // line_state_reg fields
    localparam int UMIB_LSR_READY = 0;
    localparam int UMIB_LSR_OVERRUN = 1;
    localparam int UMIB_LSR_FRAMING = 3;
    localparam int UMIB_LSR_HOLD_EMPTY = 5;
    localparam int UMIB_LSR_ALL_DONE = 6;

    // modem_state_reg fields
    localparam int UMIB_MSR_BELL_END = 2;
    localparam int UMIB_MSR_CARRIER_CHG = 3;
    localparam int UMIB_MSR_BELL = 6;
    localparam int UMIB_MSR_CARRIER = 7;

    // receive timing, in ticks of the 16x clock
    localparam logic [3:0] UMIB_TICK_HALF_M1 = 4'h7;
    localparam logic [3:0] UMIB_TICK_FULL_M1 = 4'hf;
    localparam logic [2:0] UMIB_LAST_BIT = 3'h7;
    localparam int UMIB_DATA_W = 8;
    localparam logic [7:0] UMIB_BYTE_ZERO = 8'h00;

    // receiver states, one-hot
    typedef enum logic [3:0] {
        UMIB_RX_IDLE = 4'b0001,
        UMIB_RX_START = 4'b0010,
        UMIB_RX_DATA = 4'b0100,
        UMIB_RX_STOP = 4'b1000
    } umib_rx_e;

endpackage

// ==== hw/umib_flag_if.sv ====
// carrier between the top and one modem-input detector
// assumes the owner drives the raw pin and the clear pulse
`timescale 1ns/1ps
interface umib_flag_if;
    logic pin_n;
    logic state;
    logic flag;
    logic clr;

    modport det (input pin_n, input clr, output state, output flag);
    modport owner (output pin_n, output clr, input state, input flag);
endinterface

// ==== hw/umib_edge_flag.sv ====
// one modem input: two-stage synchroniser, edge detector and sticky change flag
// assumes the pin is active low and idles high; clr is a one-cycle pulse
`timescale 1ns/1ps
module umib_edge_flag #(
    parameter bit RISE_ONLY = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    umib_flag_if.det fi
);
    logic sync1_r, sync2_r, prev_r, flag_r;
    logic flag_nxt;
    logic event_hit;

    // only prev_r and sync2_r are compared; sync1_r feeds sync2_r alone
    always_comb begin
        if (RISE_ONLY) begin
            event_hit = sync2_r & ~prev_r;
        end else begin
            event_hit = sync2_r ^ prev_r;
        end
        flag_nxt = (flag_r & ~fi.clr) | event_hit; // a new edge beats the read clear
    end

    // idle level high so leaving reset reports no change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r <= 1'b1;
            flag_r <= 1'b0;
        end else begin
            sync1_r <= fi.pin_n;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            flag_r <= flag_nxt;
        end
    end

    assign fi.state = ~sync2_r; // reads 1 while the pin is active (low)
    assign fi.flag = flag_r;
endmodule

// ==== hw/uart_modem_inputs_bus_pins.sv ====
// top of the modem-input, bus-pin and receive path of the serial element
// assumes bus pins are synchronous to clk and the 16x receive clock is below clk/2
`timescale 1ns/1ps

// Function
// R01: bell level readable at modem state bit 6
// R02: bell end flag on rising pin edge
// R03: bell end raises irq when modem enabled
// R04: bell detection not gated by terminal ready
// R05: carrier level readable at modem state bit 7
// R06: carrier change flag on any pin edge
// R07: carrier never affects the receiver
// R08: carrier change raises irq when modem enabled
// R09: hard clear idles device, clears modem control
// R10: hard clear clears line state, sets empties
// R11: stays idle until software reprograms it
// R12: irq high while any enabled source active
// R13: irq drops after service or hard clear
// R14: serial input high is mark, low space
// R15: loop mode ignores the external serial pin
// R16: strobes accepted only while selects asserted
// R17: chip selects captured under address strobe
// R18: select echo high while all selects active
// R19: transceiver off low only during cpu reads
// R20: address and selects follow strobe, hold otherwise
// R21: host pulses strobe or ties it low
// R22: receiver timed by external 16x clock
// R23: holding empty raises irq when enabled
// R24: reading modem state clears change flags
// R25: modem inputs synchronised before edge detection
module uart_modem_inputs_bus_pins
    import umib_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hard_clear,
    input wire logic bell_detect_n,
    input wire logic carrier_found_n,
    input wire logic rx_line,
    input wire logic loop_serial,
    input wire logic rx_clk16,
    input wire logic tx_hold_free,
    input wire logic tx_shift_idle,
    input wire logic latch_strobe_n,
    input wire logic sel_a,
    input wire logic sel_b,
    input wire logic sel_c_n,
    input wire logic [2:0] reg_addr,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic sel_echo,
    output logic xcvr_off,
    output logic irq_line,
    output logic term_ready_n,
    output logic send_req_n,
    output logic aux1_n,
    output logic aux2_n,
    output logic [7:0] tx_data,
    output logic tx_load
);

    // either reset source idles everything at once; both are clean, deglitched levels
    logic arst_n;
    assign arst_n = rst_n & ~hard_clear; // [R09] [R13]

    // modem input detectors
    umib_flag_if bell_if ();
    umib_flag_if carr_if ();

    logic msr_read;

    assign bell_if.pin_n = bell_detect_n; // no term_ready gating here [R04]
    assign carr_if.pin_n = carrier_found_n;
    assign bell_if.clr = msr_read; // [R24]
    assign carr_if.clr = msr_read; // [R24]

    // bell reports only the trailing (low to high) edge [R02] [R25]
    umib_edge_flag #(.RISE_ONLY(1'b1)) u_bell (
        .clk(clk),
        .arst_n(arst_n),
        .fi(bell_if)
    );

    // carrier reports both edges [R06] [R25]
    umib_edge_flag #(.RISE_ONLY(1'b0)) u_carr (
        .clk(clk),
        .arst_n(arst_n),
        .fi(carr_if)
    );

    // address strobe capture of selects and register address
    logic [2:0] addr_lat_r, addr_lat_nxt;
    logic sel_lat_r, sel_lat_nxt;

    // transparent while strobe low, holding while high [R17] [R20]
    always_comb begin
        addr_lat_nxt = addr_lat_r;
        sel_lat_nxt = sel_lat_r;
        if (!latch_strobe_n) begin
            addr_lat_nxt = reg_addr;
            sel_lat_nxt = sel_a & sel_b & ~sel_c_n;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_lat_r <= UMIB_ADDR_DATA;
            sel_lat_r <= 1'b0;
        end else begin
            addr_lat_r <= addr_lat_nxt;
            sel_lat_r <= sel_lat_nxt;
        end
    end

    // access qualification; strobes outside a selected window do nothing
    logic rd_act, wr_act;
    logic rd_prev_r, wr_prev_r;
    logic rd_edge, wr_edge;

    assign rd_act = sel_lat_r & rd_strobe; // [R16]
    assign wr_act = sel_lat_r & wr_strobe; // [R16]
    assign rd_edge = rd_act & ~rd_prev_r;
    assign wr_edge = wr_act & ~wr_prev_r;

    // clear-on-read side effects fire once per strobe, not once per cycle
    assign msr_read = rd_edge & (addr_lat_r == UMIB_ADDR_MODEM_STATE);

    logic lsr_read, rbr_read, thr_write;
    assign lsr_read = rd_edge & (addr_lat_r == UMIB_ADDR_LINE_STATE);
    assign rbr_read = rd_edge & (addr_lat_r == UMIB_ADDR_DATA);
    assign thr_write = wr_edge & (addr_lat_r == UMIB_ADDR_DATA);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end else begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
        end
    end

    // software control registers; reset leaves them cleared until reprogrammed
    logic [3:0] irq_mask_reg_r, irq_mask_reg_nxt;
    logic [4:0] modem_ctl_reg_r, modem_ctl_reg_nxt;
    logic [7:0] tx_data_r, tx_data_nxt;
    logic tx_load_r, tx_load_nxt;

    always_comb begin
        irq_mask_reg_nxt = irq_mask_reg_r;
        modem_ctl_reg_nxt = modem_ctl_reg_r;
        tx_data_nxt = tx_data_r;
        tx_load_nxt = thr_write;
        if (wr_edge && addr_lat_r == UMIB_ADDR_IRQ_MASK) begin
            irq_mask_reg_nxt = wr_data[UMIB_IRQ_MASK_W-1:0];
        end
        if (wr_edge && addr_lat_r == UMIB_ADDR_MODEM_CTL) begin
            modem_ctl_reg_nxt = wr_data[UMIB_MCTL_W-1:0];
        end
        if (thr_write) begin
            tx_data_nxt = wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_reg_r <= UMIB_IRQ_MASK_RST; // [R11]
            modem_ctl_reg_r <= UMIB_MCTL_RST; // [R09]
            tx_data_r <= UMIB_BYTE_ZERO;
            tx_load_r <= 1'b0;
        end else begin
            irq_mask_reg_r <= irq_mask_reg_nxt;
            modem_ctl_reg_r <= modem_ctl_reg_nxt;
            tx_data_r <= tx_data_nxt;
            tx_load_r <= tx_load_nxt;
        end
    end

    logic loop_mode;
    assign loop_mode = modem_ctl_reg_r[UMIB_MCTL_LOOP];

    // serial input and 16x clock synchronisers
    logic rxs1_r, rxs2_r, cks1_r, cks2_r, ck_prev_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxs1_r <= 1'b1;
            rxs2_r <= 1'b1;
            cks1_r <= 1'b0;
            cks2_r <= 1'b0;
            ck_prev_r <= 1'b0;
        end else begin
            rxs1_r <= rx_line;
            rxs2_r <= rxs1_r;
            cks1_r <= rx_clk16;
            cks2_r <= cks1_r;
            ck_prev_r <= cks2_r;
        end
    end

    logic tick;
    logic rx_bit;
    assign tick = cks2_r & ~ck_prev_r; // rising edge of the 16x clock [R22]
    // high is mark (1), low is space (0); pin unused in loop [R14] [R15]
    assign rx_bit = loop_mode ? loop_serial : rxs2_r;

    // receiver: 8 data bits, one stop; carrier is deliberately not an input here [R07]
    umib_rx_e rx_st_r, rx_st_nxt;
    logic [3:0] tcnt_r, tcnt_nxt;
    logic [2:0] bcnt_r, bcnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] rbr_r, rbr_nxt;
    logic frame_done;
    logic frame_bad;

    always_comb begin
        rx_st_nxt = rx_st_r;
        tcnt_nxt = tcnt_r;
        bcnt_nxt = bcnt_r;
        shift_nxt = shift_r;
        rbr_nxt = rbr_r;
        frame_done = 1'b0;
        frame_bad = 1'b0;
        if (tick) begin
            unique case (rx_st_r)
                UMIB_RX_IDLE: begin
                    tcnt_nxt = 4'h0;
                    if (!rx_bit) begin
                        rx_st_nxt = UMIB_RX_START;
                    end
                end
                UMIB_RX_START: begin
                    tcnt_nxt = tcnt_r + 4'h1;
                    // recheck mid-bit so a glitch does not start a frame
                    if (tcnt_r == UMIB_TICK_HALF_M1) begin
                        tcnt_nxt = 4'h0;
                        bcnt_nxt = 3'h0;
                        rx_st_nxt = rx_bit ? UMIB_RX_IDLE : UMIB_RX_DATA;
                    end
                end
                UMIB_RX_DATA: begin
                    tcnt_nxt = tcnt_r + 4'h1;
                    if (tcnt_r == UMIB_TICK_FULL_M1) begin
                        shift_nxt = {rx_bit, shift_r[7:1]}; // first bit lands in bit 0
                        bcnt_nxt = bcnt_r + 3'h1;
                        if (bcnt_r == UMIB_LAST_BIT) begin
                            rx_st_nxt = UMIB_RX_STOP;
                        end
                    end
                end
                UMIB_RX_STOP: begin
                    tcnt_nxt = tcnt_r + 4'h1;
                    if (tcnt_r == UMIB_TICK_FULL_M1) begin
                        rbr_nxt = shift_r;
                        frame_done = 1'b1;
                        frame_bad = ~rx_bit;
                        rx_st_nxt = UMIB_RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st_r <= UMIB_RX_IDLE; // serial activity suspended [R09]
            tcnt_r <= 4'h0;
            bcnt_r <= 3'h0;
            shift_r <= UMIB_BYTE_ZERO;
            rbr_r <= UMIB_BYTE_ZERO;
        end else begin
            rx_st_r <= rx_st_nxt;
            tcnt_r <= tcnt_nxt;
            bcnt_r <= bcnt_nxt;
            shift_r <= shift_nxt;
            rbr_r <= rbr_nxt;
        end
    end

    // line status flags; every set wins over a same-cycle read clear
    logic ready_r, ready_nxt;
    logic overrun_r, overrun_nxt;
    logic framing_r, framing_nxt;
    logic tx_hold_empty_r, tx_hold_empty_nxt;
    logic tx_all_done_r, tx_all_done_nxt;

    always_comb begin
        ready_nxt = (ready_r & ~rbr_read) | frame_done;
        overrun_nxt = (overrun_r & ~lsr_read) | (frame_done & ready_r & ~rbr_read);
        framing_nxt = (framing_r & ~lsr_read) | frame_bad;
        tx_hold_empty_nxt = (tx_hold_empty_r & ~thr_write) | tx_hold_free;
        tx_all_done_nxt = (tx_all_done_r & ~thr_write) | tx_shift_idle;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_r <= 1'b0; // [R10]
            overrun_r <= 1'b0; // [R10]
            framing_r <= 1'b0; // [R10]
            tx_hold_empty_r <= 1'b1; // [R10]
            tx_all_done_r <= 1'b1; // [R10]
        end else begin
            ready_r <= ready_nxt;
            overrun_r <= overrun_nxt;
            framing_r <= framing_nxt;
            tx_hold_empty_r <= tx_hold_empty_nxt;
            tx_all_done_r <= tx_all_done_nxt;
        end
    end

    // readable views of the status registers
    logic [7:0] line_state_reg;
    logic [7:0] modem_state_reg;

    always_comb begin
        line_state_reg = UMIB_BYTE_ZERO;
        line_state_reg[UMIB_LSR_READY] = ready_r;
        line_state_reg[UMIB_LSR_OVERRUN] = overrun_r;
        line_state_reg[UMIB_LSR_FRAMING] = framing_r;
        line_state_reg[UMIB_LSR_HOLD_EMPTY] = tx_hold_empty_r;
        line_state_reg[UMIB_LSR_ALL_DONE] = tx_all_done_r;
        modem_state_reg = UMIB_BYTE_ZERO;
        modem_state_reg[UMIB_MSR_BELL_END] = bell_if.flag; // [R02]
        modem_state_reg[UMIB_MSR_CARRIER_CHG] = carr_if.flag; // [R06]
        modem_state_reg[UMIB_MSR_BELL] = bell_if.state; // [R01]
        modem_state_reg[UMIB_MSR_CARRIER] = carr_if.state; // [R05]
    end

    // bus-facing outputs, all registered
    logic [7:0] rd_data_r, rd_data_nxt;
    logic sel_echo_r, xcvr_off_r, irq_line_r;
    logic irq_nxt;

    always_comb begin
        rd_data_nxt = UMIB_BYTE_ZERO;
        if (rd_act) begin
            unique case (addr_lat_r)
                UMIB_ADDR_DATA: rd_data_nxt = rbr_r;
                UMIB_ADDR_IRQ_MASK: rd_data_nxt = {4'h0, irq_mask_reg_r};
                UMIB_ADDR_MODEM_CTL: rd_data_nxt = {3'h0, modem_ctl_reg_r};
                UMIB_ADDR_LINE_STATE: rd_data_nxt = line_state_reg;
                UMIB_ADDR_MODEM_STATE: rd_data_nxt = modem_state_reg;
                default: rd_data_nxt = UMIB_BYTE_ZERO; // unmapped codes read zero
            endcase
        end
        // level interrupt: it falls one clk cycle after the serviced flag clears, through irq_line_r [R12] [R13]
        irq_nxt = (irq_mask_reg_r[UMIB_IRQ_RX_AVAIL] & ready_r)
            | (irq_mask_reg_r[UMIB_IRQ_TX_EMPTY] & tx_hold_empty_r) // [R23]
            | (irq_mask_reg_r[UMIB_IRQ_LINE_ERR] & (overrun_r | framing_r))
            | (irq_mask_reg_r[UMIB_IRQ_MODEM] & (bell_if.flag | carr_if.flag)); // [R03] [R08]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_r <= UMIB_BYTE_ZERO;
            sel_echo_r <= 1'b0;
            xcvr_off_r <= 1'b1;
            irq_line_r <= 1'b0; // [R13]
        end else begin
            rd_data_r <= rd_data_nxt;
            sel_echo_r <= sel_lat_r; // [R18]
            xcvr_off_r <= ~rd_act; // [R19]
            irq_line_r <= irq_nxt; // [R12]
        end
    end

    // modem control pins; active low, forced inactive by reset
    logic term_ready_n_r, send_req_n_r, aux1_n_r, aux2_n_r;

    // aux pins go inactive in loop mode; terminal ready and send request still follow modem_ctl_reg during self test
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            term_ready_n_r <= 1'b1; // [R09]
            send_req_n_r <= 1'b1; // [R09]
            aux1_n_r <= 1'b1; // [R09]
            aux2_n_r <= 1'b1; // [R09]
        end else begin
            term_ready_n_r <= ~modem_ctl_reg_r[UMIB_MCTL_TERM_READY];
            send_req_n_r <= ~modem_ctl_reg_r[UMIB_MCTL_SEND_REQ];
            aux1_n_r <= ~(modem_ctl_reg_r[UMIB_MCTL_AUX1] & ~loop_mode);
            aux2_n_r <= ~(modem_ctl_reg_r[UMIB_MCTL_AUX2] & ~loop_mode);
        end
    end

    assign rd_data = rd_data_r;
    assign sel_echo = sel_echo_r;
    assign xcvr_off = xcvr_off_r;
    assign irq_line = irq_line_r;
    assign term_ready_n = term_ready_n_r;
    assign send_req_n = send_req_n_r;
    assign aux1_n = aux1_n_r;
    assign aux2_n = aux2_n_r;
    assign tx_data = tx_data_r;
    assign tx_load = tx_load_r;

endmodule

// ==== dv/umib_checker.sv ====
// checker: port-level timing of the bus pins, reset levels and transmit load
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module umib_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hard_clear,
    input wire logic latch_strobe_n,
    input wire logic sel_a,
    input wire logic sel_b,
    input wire logic sel_c_n,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic sel_echo,
    input wire logic xcvr_off,
    input wire logic irq_line,
    input wire logic term_ready_n,
    input wire logic send_req_n,
    input wire logic aux1_n,
    input wire logic aux2_n,
    input wire logic [7:0] tx_data,
    input wire logic tx_load
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || hard_clear);
    logic sel_ok;
    // all three selects active while the strobe is open
    assign sel_ok = !latch_strobe_n && sel_a && sel_b && !sel_c_n;
    // a read with the selects held in the latch
    sequence s_rd_go;
        sel_echo && latch_strobe_n && rd_strobe;
    endsequence
    sequence s_load_seen;
        $rose(tx_load);
    endsequence
    a_echo_on: assert property (sel_ok |-> ##2 sel_echo)
        else $error("select echo did not rise");
    a_echo_off: assert property ((!latch_strobe_n && !sel_ok) |-> ##2 !sel_echo)
        else $error("select echo high without all selects");
    a_xcvr_read: assert property (s_rd_go |=> !xcvr_off)
        else $error("transceiver not released during read");
    a_xcvr_idle: assert property (!rd_strobe |=> xcvr_off)
        else $error("transceiver released without read");
    a_rd_quiet: assert property (!rd_strobe |=> rd_data == 8'h00)
        else $error("read data driven without read");
    // reset is the antecedent here, so this one stays armed through it
    a_reset_outs: assert property (disable iff (1'b0) (!rst_n || hard_clear) |->
        (term_ready_n && send_req_n && aux1_n && aux2_n && !irq_line && xcvr_off))
        else $error("outputs not cleared by reset");
    a_load_once: assert property (tx_load |=> !tx_load)
        else $error("load pulse longer than one cycle");
    a_load_data: assert property (s_load_seen |-> $past(wr_strobe) &&
        tx_data == $past(wr_data))
        else $error("load without matching write");
endmodule
bind uart_modem_inputs_bus_pins umib_checker chk (.clk, .rst_n, .hard_clear, .latch_strobe_n,
    .sel_a, .sel_b, .sel_c_n, .rd_strobe, .wr_strobe, .wr_data, .rd_data, .sel_echo,
    .xcvr_off, .irq_line, .term_ready_n, .send_req_n, .aux1_n, .aux2_n, .tx_data, .tx_load);

// ==== dv/umib_modem_model.sv ====
// modem data set model: ring and carrier pins, serial line, 16x receive clock
// assumes frames of 8 data bits and one stop bit, 16 ticks a bit
`timescale 1ns/1ps
module umib_modem_model (
    input wire logic clk,
    output logic bell_detect_n,
    output logic carrier_found_n,
    output logic rx_line,
    output logic rx_clk16
);
    logic [1:0] div = 2'h0;
    initial begin
        bell_detect_n = 1'b1;
        carrier_found_n = 1'b1;
        rx_line = 1'b1; // idle line is mark
    end
    // 16x clock at clk/4, two cycles high and two low so the sync sees both
    always @(negedge clk) begin
        div <= div + 2'h1;
    end
    assign rx_clk16 = div[1];
    task automatic ring(input logic lvl);
        @(negedge clk);
        bell_detect_n = lvl;
    endtask
    task automatic carrier(input logic lvl);
        @(negedge clk);
        carrier_found_n = lvl;
    endtask
    // one bit is 16 ticks of 4 clocks; lsb first
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rx_line = f[i]; // high is mark, low is space
            repeat (63) @(negedge clk);
        end
    endtask
endmodule

// ==== dv/uart_modem_inputs_bus_pins_bench.sv ====
// bench for the modem-input and bus-pin block, self-checking
// assumes the checker is bound by its own file and the modem model drives the pins
`timescale 1ns/1ps
module uart_modem_inputs_bus_pins_bench;
    import umib_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    logic hard_clear = 1'b0;
    logic loop_serial = 1'b1;
    logic tx_hold_free = 1'b0;
    logic tx_shift_idle = 1'b0;
    logic latch_strobe_n = 1'b1;
    logic sel_a = 1'b0;
    logic sel_b = 1'b0;
    logic sel_c_n = 1'b1;
    logic [2:0] off_pins = 3'h2; // {sel_a, sel_b, sel_c_n} for a deselected access
    logic rd_strobe = 1'b0;
    logic wr_strobe = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic bell_detect_n, carrier_found_n, rx_line, rx_clk16;
    logic [7:0] rd_data, tx_data, q;
    logic sel_echo, xcvr_off, irq_line, term_ready_n, send_req_n, aux1_n, aux2_n, tx_load;
    int bad_count = 0;
    int checks = 0;
    always #50 clk = ~clk;
    uart_modem_inputs_bus_pins dut (.clk, .rst_n, .hard_clear, .bell_detect_n,
        .carrier_found_n, .rx_line, .loop_serial, .rx_clk16, .tx_hold_free, .tx_shift_idle,
        .latch_strobe_n, .sel_a, .sel_b, .sel_c_n, .reg_addr, .rd_strobe, .wr_strobe,
        .wr_data, .rd_data, .sel_echo, .xcvr_off, .irq_line, .term_ready_n, .send_req_n,
        .aux1_n, .aux2_n, .tx_data, .tx_load);
    umib_modem_model modem (.clk, .bell_detect_n, .carrier_found_n, .rx_line, .rx_clk16);
    task automatic end_of_test();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic lv(input logic s, input logic e);
        chk({7'h00, s}, {7'h00, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one access: strobe pulsed low to latch, then pins scrambled while it holds
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
        input logic sel, output logic [7:0] r);
        int n;
        @(negedge clk);
        latch_strobe_n = 1'b0; // multiplexed host pulses the strobe
        reg_addr = a;
        {sel_a, sel_b, sel_c_n} = sel ? 3'h6 : off_pins;
        wr_data = d;
        n = 0;
        cyc(2); // echo from the last access is stale until latch and echo follow
        // host waits for the echo before any transfer
        while (sel_echo !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        if (sel && n == 6) begin
            bad_count++;
            end_of_test();
        end
        lv(sel_echo, sel);
        latch_strobe_n = 1'b1;
        reg_addr = ~a; // latched copy must hold
        sel_a = 1'b0;
        rd_strobe = !w;
        wr_strobe = w;
        @(negedge clk);
        r = rd_data;
        lv(xcvr_off, w | !sel);
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        cyc(2);
    endtask
    task automatic t_reset();
        bus(0, 3'h5, 8'h00, 1, q);
        chk(q, 8'h60);
        bus(0, 3'h6, 8'h00, 1, q);
        chk(q, 8'h00);
        bus(0, 3'h7, 8'h00, 1, q);
        chk(q, 8'h00);
    endtask
    // terminal ready stays inactive throughout: ring still detected
    task automatic t_bell();
        modem.ring(1'b0);
        bus(0, 3'h6, 8'h00, 1, q);
        chk(q, 8'h40);
        modem.ring(1'b1);
        // each select dropped alone must block the read and its clear
        for (int i = 0; i < 3; i++) begin
            off_pins = (i == 2) ? 3'h7 : 3'h2 << i;
            bus(0, 3'h6, 8'h00, 0, q);
            chk(q, 8'h00);
        end
        bus(0, 3'h6, 8'h00, 1, q);
        chk(q, 8'h04);
        bus(0, 3'h6, 8'h00, 1, q);
        chk(q, 8'h00);
        lv(term_ready_n, 1'b1);
    endtask
    // carrier moves mid-frame; the byte must still arrive intact
    task automatic t_rx();
        fork
            modem.send_byte(8'ha5);
            begin
                cyc(300);
                modem.carrier(1'b0);
            end
        join
        cyc(4);
        bus(0, 3'h5, 8'h00, 1, q);
        chk(q, 8'h61);
        bus(0, 3'h0, 8'h00, 1, q);
        chk(q, 8'ha5);
        bus(0, 3'h6, 8'h00, 1, q);
        chk(q, 8'h88);
        modem.carrier(1'b1);
        bus(0, 3'h6, 8'h00, 1, q);
        chk(q, 8'h08);
    endtask
    task automatic t_irq();
        bus(1, 3'h1, 8'h08, 1, q);
        modem.carrier(1'b0);
        cyc(6);
        lv(irq_line, 1'b1);
        bus(0, 3'h6, 8'h00, 1, q);
        lv(irq_line, 1'b0);
        modem.ring(1'b0);
        cyc(6);
        lv(irq_line, 1'b0);
        modem.ring(1'b1);
        cyc(6);
        lv(irq_line, 1'b1);
        bus(0, 3'h6, 8'h00, 1, q);
        bus(1, 3'h1, 8'h02, 1, q);
        lv(irq_line, 1'b1);
        bus(1, 3'h0, 8'h3c, 1, q);
        chk(tx_data, 8'h3c);
        lv(irq_line, 1'b0);
        tx_hold_free = 1'b1;
        cyc(1);
        tx_hold_free = 1'b0;
        cyc(3);
        lv(irq_line, 1'b1);
        bus(1, 3'h1, 8'h00, 1, q);
        lv(irq_line, 1'b0);
    endtask
    // loop mode: a frame on the outside pin must not be received
    task automatic t_loop();
        bus(1, 3'h4, 8'h1f, 1, q);
        chk({4'h0, term_ready_n, send_req_n, aux1_n, aux2_n}, 8'h03);
        modem.send_byte(8'h00);
        cyc(4);
        bus(0, 3'h5, 8'h00, 1, q);
        chk(q, 8'h20);
        // a held-low loop path gives a zero byte with a bad stop bit
        loop_serial = 1'b0;
        tx_shift_idle = 1'b1;
        cyc(630);
        loop_serial = 1'b1;
        tx_shift_idle = 1'b0;
        cyc(40);
        bus(0, 3'h5, 8'h00, 1, q);
        chk(q, 8'h69);
    endtask
    task automatic t_clear();
        bus(1, 3'h1, 8'h02, 1, q);
        lv(irq_line, 1'b1);
        @(negedge clk);
        hard_clear = 1'b1;
        cyc(1);
        lv(irq_line, 1'b0);
        chk({4'h0, term_ready_n, send_req_n, aux1_n, aux2_n}, 8'h0f);
        hard_clear = 1'b0;
        cyc(3);
        bus(0, 3'h4, 8'h00, 1, q);
        chk(q, 8'h00);
        bus(0, 3'h5, 8'h00, 1, q);
        chk(q, 8'h60);
        lv(irq_line, 1'b0);
    endtask
    initial begin
        @(negedge clk);
        rst_n = 1'b0;
        cyc(16);
        rst_n = 1'b1;
        cyc(3);
        t_reset();
        t_bell();
        t_rx();
        t_irq();
        t_loop();
        t_clear();
        end_of_test();
    end
endmodule
